// ---- verilog/oam_pkg.sv ----
// Shared constants and types for the OR/move instruction subset
package oam_pkg;

  localparam int OAM_DATA_W  = 8;
  localparam int OAM_INSTR_W = 12;
  localparam int OAM_ADDR_W  = 5;

  // Opcode patterns, compared against the top bits of the word
  localparam int                 OAM_LIT_OPC_W  = 4;
  localparam int                 OAM_REG_OPC_W  = 6;
  localparam logic [3:0]         OAM_OPC_OR_LIT   = 4'hD;
  localparam logic [3:0]         OAM_OPC_LOAD_LIT = 4'hC;
  localparam logic [5:0]         OAM_OPC_OR_REG   = 6'h04;
  localparam logic [5:0]         OAM_OPC_MOVE_REG = 6'h08;

  // Field positions
  localparam int OAM_LIT_LSB  = 0;
  localparam int OAM_ADDR_LSB = 0;
  localparam int OAM_DEST_BIT = 5;

  // Reset values
  localparam logic [7:0] OAM_ACC_RST  = 8'h00;
  localparam logic       OAM_ZERO_RST = 1'b0;

  typedef enum {
    OAM_OP_NONE,
    OAM_OP_OR_LIT,
    OAM_OP_OR_REG,
    OAM_OP_MOVE_REG,
    OAM_OP_LOAD_LIT
  } oam_op_e;

  typedef struct packed {
    logic [OAM_DATA_W-1:0] acc;
    logic                  zero;
    logic                  file_we;
    logic [OAM_ADDR_W-1:0] file_waddr;
    logic [OAM_DATA_W-1:0] file_wdata;
    logic                  done;
    logic                  unsupported;
  } oam_state_s;

endpackage

// ---- verilog/oam_dec_if.sv ----
// Decoded instruction fields passed from decoder to core
`timescale 1ns/1ps
interface oam_dec_if;
  import oam_pkg::*;

  logic [OAM_INSTR_W-1:0] instr;
  oam_op_e                op;
  logic [OAM_DATA_W-1:0]  literal;
  logic [OAM_ADDR_W-1:0]  addr;
  logic                   dest;

  modport dec  (input instr, output op, output literal, output addr, output dest);
  modport core (output instr, input op, input literal, input addr, input dest);
endinterface

// ---- verilog/oam_decode.sv ----
// Opcode and operand field decoder
`timescale 1ns/1ps
module oam_decode
  import oam_pkg::*;
(
  oam_dec_if.dec d
);

  logic [OAM_LIT_OPC_W-1:0] top_lit;
  logic [OAM_REG_OPC_W-1:0] top_reg;

  assign top_lit   = d.instr[OAM_INSTR_W-1 -: OAM_LIT_OPC_W];
  assign top_reg   = d.instr[OAM_INSTR_W-1 -: OAM_REG_OPC_W];
  // Full 0..255 literal, no sign extension
  assign d.literal = d.instr[OAM_LIT_LSB +: OAM_DATA_W];
  // Five-bit register select, registers 0..31
  assign d.addr    = d.instr[OAM_ADDR_LSB +: OAM_ADDR_W];
  assign d.dest    = d.instr[OAM_DEST_BIT];

  always_comb begin
    if (top_lit == OAM_OPC_OR_LIT) begin
      d.op = OAM_OP_OR_LIT;
    end else if (top_lit == OAM_OPC_LOAD_LIT) begin
      d.op = OAM_OP_LOAD_LIT;
    end else if (top_reg == OAM_OPC_OR_REG) begin
      d.op = OAM_OP_OR_REG;
    end else if (top_reg == OAM_OPC_MOVE_REG) begin
      d.op = OAM_OP_MOVE_REG;
    end else begin
      d.op = OAM_OP_NONE;
    end
  end

endmodule // oam_decode

// ---- verilog/oam_core.sv ----
// Execute logic for OR-literal, OR-register, move-register, load-literal
`timescale 1ns/1ps
module oam_core
  import oam_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   instr_valid,
  input  wire logic [OAM_INSTR_W-1:0] instr,
  output      logic [OAM_ADDR_W-1:0]  file_raddr,
  input  wire logic [OAM_DATA_W-1:0]  file_rdata,
  output      logic                   file_we,
  output      logic [OAM_ADDR_W-1:0]  file_waddr,
  output      logic [OAM_DATA_W-1:0]  file_wdata,
  output      logic [OAM_DATA_W-1:0]  acc,
  output      logic                   zero_flag,
  output      logic                   instr_done,
  output      logic                   instr_unsupported
);

  oam_dec_if  dif ();
  oam_state_s st_q;
  oam_state_s st_d;

  logic [OAM_DATA_W-1:0] result;

  assign dif.instr = instr;

  oam_decode u_decode (
    .d (dif.dec)
  );

  // Register read is combinational so the operand is ready in the same cycle
  assign file_raddr = dif.addr;

  always_comb begin
    st_d             = st_q;
    st_d.file_we     = 1'b0;
    st_d.done        = 1'b0;
    st_d.unsupported = 1'b0;
    result           = '0;
    if (instr_valid) begin
      st_d.done = 1'b1;
      unique case (dif.op)
        OAM_OP_OR_LIT: begin
          result    = st_q.acc | dif.literal;
          st_d.acc  = result;
          st_d.zero = (result == '0);
        end
        OAM_OP_OR_REG: begin
          result    = st_q.acc | file_rdata;
          st_d.zero = (result == '0);
          if (dif.dest) begin
            st_d.file_we    = 1'b1;
            st_d.file_waddr = dif.addr;
            st_d.file_wdata = result;
          end else begin
            st_d.acc = result;
          end
        end
        OAM_OP_MOVE_REG: begin
          result    = file_rdata;
          st_d.zero = (result == '0);
          if (dif.dest) begin
            st_d.file_we    = 1'b1;
            st_d.file_waddr = dif.addr;
            st_d.file_wdata = result;
          end else begin
            st_d.acc = result;
          end
        end
        OAM_OP_LOAD_LIT: begin
          st_d.acc = dif.literal;
        end
        OAM_OP_NONE: begin
          st_d.done        = 1'b0;
          st_d.unsupported = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q             <= '0;
      st_q.acc         <= OAM_ACC_RST;
      st_q.zero        <= OAM_ZERO_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign acc               = st_q.acc;
  assign zero_flag         = st_q.zero;
  assign file_we           = st_q.file_we;
  assign file_waddr        = st_q.file_waddr;
  assign file_wdata        = st_q.file_wdata;
  assign instr_done        = st_q.done;
  assign instr_unsupported = st_q.unsupported;

  // Local copies of the decode for the checks below
  oam_op_e               chk_op;
  logic [OAM_DATA_W-1:0] chk_lit;
  logic [OAM_ADDR_W-1:0] chk_addr;
  logic                  chk_dest;

  assign chk_op   = dif.op;
  assign chk_lit  = dif.literal;
  assign chk_addr = dif.addr;
  assign chk_dest = dif.dest;

  // Issue strobes as the core sees them; a reset edge executes nothing
  logic                  chk_take;
  logic                  chk_supported;
  logic                  chk_wb;

  assign chk_take      = rst_n && instr_valid;
  assign chk_supported = chk_take && chk_op != OAM_OP_NONE;
  assign chk_wb        = chk_take && chk_dest
                         && (chk_op == OAM_OP_OR_REG || chk_op == OAM_OP_MOVE_REG);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_issue(oam_op_e op_k);
    chk_take && chk_op == op_k;
  endsequence

  sequence s_issue_dest(oam_op_e op_k, logic d_k);
    chk_take && chk_op == op_k && chk_dest == d_k;
  endsequence

  property p_or_lit;
    s_issue(OAM_OP_OR_LIT) |=>
      acc == ($past(acc) | $past(chk_lit)) && zero_flag == (acc == '0) && !file_we;
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("OR literal result wrong");

  property p_lit_full_range;
    s_issue(OAM_OP_LOAD_LIT) |=> acc == $past(instr[7:0]);
  endproperty
  a_lit_full_range: assert property (p_lit_full_range) else $error("Literal truncated");

  property p_or_reg_acc;
    s_issue_dest(OAM_OP_OR_REG, 1'b0) |=>
      acc == ($past(acc) | $past(file_rdata)) && zero_flag == (acc == '0) && !file_we;
  endproperty
  a_or_reg_acc: assert property (p_or_reg_acc) else $error("OR register to acc wrong");

  property p_or_reg_file;
    s_issue_dest(OAM_OP_OR_REG, 1'b1) |=>
      file_we && file_wdata == ($past(acc) | $past(file_rdata))
      && acc == $past(acc) && zero_flag == (file_wdata == '0);
  endproperty
  a_or_reg_file: assert property (p_or_reg_file) else $error("OR register writeback wrong");

  property p_addr;
    chk_wb |-> file_raddr == instr[4:0] ##1 file_waddr == $past(instr[4:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("Register address field wrong");

  property p_move_acc;
    s_issue_dest(OAM_OP_MOVE_REG, 1'b0) |=> acc == $past(file_rdata) && !file_we;
  endproperty
  a_move_acc: assert property (p_move_acc) else $error("Move to acc wrong");

  property p_move_acc_zero;
    s_issue_dest(OAM_OP_MOVE_REG, 1'b0) |=> zero_flag == ($past(file_rdata) == '0);
  endproperty
  a_move_acc_zero: assert property (p_move_acc_zero) else $error("Move to acc Z wrong");

  property p_move_self_zero;
    s_issue_dest(OAM_OP_MOVE_REG, 1'b1) |=>
      file_we && file_wdata == $past(file_rdata) && acc == $past(acc)
      && zero_flag == ($past(file_rdata) == '0);
  endproperty
  a_move_self_zero: assert property (p_move_self_zero) else $error("Move writeback Z wrong");

  property p_load_flags;
    s_issue(OAM_OP_LOAD_LIT) |=> $stable(zero_flag) && !file_we;
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("Load literal touched flags");

  property p_one_cycle;
    chk_supported |=> instr_done ##1 (instr_done == $past(chk_supported));
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("Instruction not one cycle");

  property p_idle_quiet;
    rst_n && !instr_valid |=> !instr_done && !file_we && $stable(acc) && $stable(zero_flag);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("State changed with no instruction");

  property p_unsup_quiet;
    s_issue(OAM_OP_NONE) |=> instr_unsupported && !instr_done && !file_we
      && $stable(acc) && $stable(zero_flag);
  endproperty
  a_unsup_quiet: assert property (p_unsup_quiet) else $error("Unknown word not ignored");

  property p_done_excl;
    !(instr_done && instr_unsupported);
  endproperty
  a_done_excl: assert property (p_done_excl) else $error("Done with unsupported");

  property p_we_cause;
    file_we |-> $past(chk_wb);
  endproperty
  a_we_cause: assert property (p_we_cause) else $error("Write with no writeback instruction");

  property p_read_addr;
    chk_take && (chk_op == OAM_OP_OR_REG || chk_op == OAM_OP_MOVE_REG)
      |-> file_raddr == instr[4:0];
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("Read address field wrong");

endmodule // oam_core

// ---- test/oam_file_model.sv ----
// Behavioural file register datapath facing the core
`timescale 1ns/1ps
module oam_file_model
  import oam_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic [OAM_ADDR_W-1:0] file_raddr,
  output      logic [OAM_DATA_W-1:0] file_rdata,
  input  wire logic                  file_we,
  input  wire logic [OAM_ADDR_W-1:0] file_waddr,
  input  wire logic [OAM_DATA_W-1:0] file_wdata
);
  logic [OAM_DATA_W-1:0] mem [32];
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 8'(i * 17);
  end
  always_ff @(posedge ref_clk) begin
    if (file_we) mem[file_waddr] <= file_wdata;
  end
  // Forward a write still in flight to a same-address read
  assign file_rdata = (file_we && file_waddr == file_raddr) ? file_wdata : mem[file_raddr];
endmodule // oam_file_model

// ---- test/testbench.sv ----
// Self-checking bench for the instruction subset core
`timescale 1ns/1ps
module testbench
  import oam_pkg::*;
;
  typedef struct packed {
    logic [11:0] ins;
    logic [7:0]  acc;
    logic        z;
    logic        we;
    logic [7:0]  wd;
  } oam_row_s;
  logic                   ref_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   instr_valid = 1'b0;
  logic [OAM_INSTR_W-1:0] instr = 12'h000;
  logic [OAM_ADDR_W-1:0]  file_raddr, file_waddr;
  logic [OAM_DATA_W-1:0]  file_rdata, file_wdata, acc;
  logic                   file_we, zero_flag, instr_done, instr_unsupported;
  int                     err_total = 0;
  int                     n_checks = 0;
  oam_row_s               rows [12] = '{
    '{12'hC5A, 8'h5A, 1'b0, 1'b0, 8'h00}, '{12'hD35, 8'h7F, 1'b0, 1'b0, 8'h00},
    '{12'hC00, 8'h00, 1'b0, 1'b0, 8'h00}, '{12'hD00, 8'h00, 1'b1, 1'b0, 8'h00},
    '{12'hCFF, 8'hFF, 1'b1, 1'b0, 8'h00}, '{12'h200, 8'h00, 1'b1, 1'b0, 8'h00},
    '{12'h203, 8'h33, 1'b0, 1'b0, 8'h00}, '{12'h11F, 8'h3F, 1'b0, 1'b0, 8'h00},
    '{12'h123, 8'h3F, 1'b0, 1'b1, 8'h3F}, '{12'h223, 8'h3F, 1'b0, 1'b1, 8'h3F},
    '{12'h220, 8'h3F, 1'b1, 1'b1, 8'h00}, '{12'hD80, 8'hBF, 1'b0, 1'b0, 8'h00}};

  always #12.5 ref_clk = ~ref_clk;

  oam_core oam_core_i (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag),
    .instr_done(instr_done), .instr_unsupported(instr_unsupported));
  oam_file_model oam_file_model_i (.ref_clk(ref_clk), .file_raddr(file_raddr),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata));

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_idle(logic [7:0] a, logic z);
    chk("acc", a, acc);
    chk("zero", {7'h00, z}, {7'h00, zero_flag});
    chk("done", 8'h00, {7'h00, instr_done});
    chk("we", 8'h00, {7'h00, file_we});
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk_idle(8'h00, 1'b0);
    $display("reset test done");
    // Back to back, one word per cycle
    for (int i = 0; i <= 12; i++) begin
      @(posedge ref_clk);
      instr_valid <= (i < 12);
      if (i < 12) instr <= rows[i].ins;
      if (i > 0) begin
        #1;
        chk("acc", rows[i-1].acc, acc);
        chk("zero", {7'h00, rows[i-1].z}, {7'h00, zero_flag});
        chk("done", 8'h01, {7'h00, instr_done});
        chk("we", {7'h00, rows[i-1].we}, {7'h00, file_we});
        if (rows[i-1].we) begin
          chk("wdata", rows[i-1].wd, file_wdata);
          chk("waddr", {3'h0, rows[i-1].ins[4:0]}, {3'h0, file_waddr});
        end
      end
    end
    $display("instruction table test done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    instr_valid <= 1'b1;
    instr <= 12'hF00;
    #1;
    chk_idle(8'h00, 1'b0);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    chk("unsup", 8'h01, {7'h00, instr_unsupported});
    chk_idle(8'h00, 1'b0);
    @(posedge ref_clk);
    #1;
    chk("unsup", 8'h00, {7'h00, instr_unsupported});
    $display("mid-run reset and unsupported test done");
    tally_and_finish();
  end

  initial begin
    repeat (200) @(posedge ref_clk);
    err_total++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule // testbench
